// ==== common/adc_cfg_defines.svh ====
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS   25
`define SCLK_HALF_NS    100
`define SCLK_HALF_CYC   (`SCLK_HALF_NS / `CLK_PERIOD_NS)
`define CS_HIGH_NS      50
`define CS_HIGH_CYC     ((`CS_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// Frame layout: {op[3:0], address[7:0], data[7:0]}
// ****************************************************************
`define WORD_BITS       20
`define CMD_OP_LSB      16
`define CMD_ADDR_LSB    8
`define MAX_CHAIN       4
`define STAR_SLOTS      4

// ****************************************************************
// Device register map
// ****************************************************************
`define ADDR_POWER      8'h10
`define ADDR_KEY        8'h11
`define KEY_VALUE       8'h69
`define ADDR_INPUT      8'h14
`define ADDR_OUTPUT     8'h18
`define ADDR_WORD       8'h1c
`define CFG_RESET       8'h00
`define POWER_MASK      8'h03
`define INPUT_MASK      8'h03
`define OUTPUT_MASK     8'hdf
`define WORD_MASK       8'h3f
`define PWR_DOWN_BIT    0
`define PWR_NAP_BIT     1
`define OUT_MODE_LSB    0
`define OUT_LANE_LSB    2
`define OUT_RATE_BIT    4
`define OUT_RSVD_BIT    5
`define OUT_CLKSEL_LSB  6

// ****************************************************************
// Host register map
// ****************************************************************
`define HOST_COMMAND    8'h00
`define HOST_CONTROL    8'h04
`define HOST_STATUS     8'h08
`define HOST_RECEIVE    8'h0c
`define CTL_CPHA_BIT    0
`define CTL_CPOL_BIT    1
`define CTL_CHAIN_LSB   2
`define CTL_TARGET_LSB  4

`endif

// ==== common/adc_cfg_pkg.sv ====
package adc_cfg_pkg;
`include "adc_cfg_defines.svh"

   typedef logic [`WORD_BITS-1:0] word_t;

   typedef enum logic [3:0] {
      op_nop   = 4'h0,
      op_write = 4'h1,
      op_read  = 4'h2
   } op_e;

   typedef enum logic [1:0] {
      rd_follow      = 2'b00,
      rd_bad_lo      = 2'b01,
      rd_bad_hi      = 2'b10,
      rd_source_sync = 2'b11
   } read_mode_e;

   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_shift = 2'b01,
      st_tail  = 2'b10,
      st_gap   = 2'b11
   } host_state_e;

endpackage : adc_cfg_pkg

// ==== common/adc_cfg_if.sv ====
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
interface adc_cfg_if;
   logic [`STAR_SLOTS-1:0] cs_n;
   logic                   sclk;
   logic                   sdi;
   logic [3:0]             lane_out;
   logic [3:0]             lane_oe;
   logic [3:0]             lane;
   logic                   ss_clk;

   // Undriven lanes read low
   assign lane = lane_out & lane_oe;

   modport device (input cs_n, input sclk, input sdi,
                   output lane_out, output lane_oe, output ss_clk);
   modport host   (output cs_n, output sclk, output sdi,
                   input lane, input ss_clk);
endinterface : adc_cfg_if

// ==== logic/serial_edge_detect.sv ====
`timescale 1ns/1ps
module serial_edge_detect (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic cpol,
   input  wire logic cpha,
   output      logic capture,
   output      logic launch,
   output      logic frame_start,
   output      logic frame_end
);
   logic sclk_q;
   logic cs_q;
   logic leading;
   logic trailing;

   // Previous pin levels for edge detection
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
      end else begin
         sclk_q <= sclk;
         cs_q   <= cs_n;
      end
   end

   // Edges count only inside a frame, so a stale level at reset is harmless
   assign leading     = !cs_n && (cpol ? (sclk_q && !sclk) : (!sclk_q && sclk));
   assign trailing    = !cs_n && (cpol ? (!sclk_q && sclk) : (sclk_q && !sclk));
   assign capture     = cpha ? trailing : leading;
   assign launch      = cpha ? leading : trailing;
   assign frame_start = cs_q && !cs_n;
   assign frame_end   = !cs_q && cs_n;
endmodule : serial_edge_detect

// ==== logic/adc_cfg_device.sv ====
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_device #(
   parameter int SLOT = 0
) (
   input  wire logic                    clock,
   input  wire logic                    resetn,
   adc_cfg_if.device                    link,
   output      logic                    power_down_request,
   output      logic                    light_sleep_enable,
   output      logic [1:0]              write_port_spi_mode,
   output      adc_cfg_pkg::read_mode_e read_protocol_select,
   output      logic [1:0]              output_lane_count,
   output      logic [1:0]              source_sync_clock_select,
   output      logic                    data_rate_double,
   output      logic [5:0]              output_word_config,
   output      logic                    command_done
);
   import adc_cfg_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [4:0] lane_step(input logic [1:0] code);
      case (code)
         2'b10:   lane_step = 5'd2;
         2'b11:   lane_step = 5'd4;
         default: lane_step = 5'd1;
      endcase
   endfunction : lane_step
   function automatic logic [3:0] lane_chunk(input word_t w, input logic [1:0] code);
      case (code)
         2'b10:   lane_chunk = {2'b00, w[18], w[19]};
         2'b11:   lane_chunk = {w[16], w[17], w[18], w[19]};
         default: lane_chunk = {3'b000, w[19]};
      endcase
   endfunction : lane_chunk
   // ****************************************************************
   // Registers and decode
   // ****************************************************************
   logic       cs_n, capture, launch, frame_start, frame_end;
   logic [1:0] power_bits, input_protocol_select;
   logic [7:0] output_protocol_select;
   logic [5:0] word_bits;
   logic       key_armed, sdo_q, is_write;
   word_t      unified_shift_reg, resp;
   logic [3:0] f_op;
   logic [7:0] f_addr, f_data, rd_value;
   assign cs_n     = link.cs_n[SLOT];
   assign f_op     = unified_shift_reg[`WORD_BITS-1:`CMD_OP_LSB];
   assign f_addr   = unified_shift_reg[`CMD_OP_LSB-1:`CMD_ADDR_LSB];
   assign f_data   = unified_shift_reg[`CMD_ADDR_LSB-1:0];
   assign is_write = frame_end && (f_op == op_write);
   serial_edge_detect u_edges (
      .clock       (clock),
      .resetn      (resetn),
      .sclk        (link.sclk),
      .cs_n        (cs_n),
      .cpol        (input_protocol_select[1]),
      .cpha        (input_protocol_select[0]),
      .capture     (capture),
      .launch      (launch),
      .frame_start (frame_start),
      .frame_end   (frame_end)
   );
   // Key arms on the key write; any other write disarms it
   // one-shot unlock key
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         key_armed <= 1'b0;
      end else if (is_write) begin
         key_armed <= (f_addr == `ADDR_KEY) && (f_data == `KEY_VALUE);
      end
   end
   // Power control, only accepted while armed
   // zero after reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         power_bits <= 2'(`CFG_RESET);
      end else if (is_write && f_addr == `ADDR_POWER && key_armed) begin
         power_bits <= f_data[1:0];
      end
   end
   // Configuration takes effect only between frames, never mid-shift
   // register decode
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         input_protocol_select  <= 2'(`CFG_RESET);
         output_protocol_select <= `CFG_RESET;
         word_bits              <= 6'(`CFG_RESET);
      end else if (is_write) begin
         case (f_addr)
            `ADDR_INPUT:  input_protocol_select  <= f_data[1:0];
            `ADDR_OUTPUT: output_protocol_select <= f_data & `OUTPUT_MASK;
            `ADDR_WORD:   word_bits              <= f_data[5:0];
            default:      ;
         endcase
      end
   end
   // Read-back value
   // reserved bits zero
   always_comb begin
      case (f_addr)
         `ADDR_POWER:  rd_value = {6'h00, power_bits} & `POWER_MASK;
         `ADDR_INPUT:  rd_value = {6'h00, input_protocol_select} & `INPUT_MASK;
         `ADDR_OUTPUT: rd_value = output_protocol_select & `OUTPUT_MASK;
         `ADDR_WORD:   rd_value = {2'b00, word_bits} & `WORD_MASK;
         default:      rd_value = 8'h00;
      endcase
   end
   // Answer shown in the next frame: read data, or the echo of the command
   // decode at chip-select rise
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         resp         <= '0;
         command_done <= 1'b0;
      end else begin
         command_done <= frame_end;
         if (frame_end) begin
            resp <= {f_op, f_addr, (f_op == op_read) ? rd_value : f_data};
         end
      end
   end

   // ****************************************************************
   // Unified shift register
   // ****************************************************************
   // In a chain the same register passes bits to the next device
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         unified_shift_reg <= '0;
      end else if (frame_start) begin
         unified_shift_reg <= resp;
      end else if (capture) begin
         unified_shift_reg <= {unified_shift_reg[`WORD_BITS-2:0], link.sdi};
      end
   end
   // Phase 0 needs its first bit before the first edge
   // output follows input mode
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sdo_q <= 1'b0;
      end else if (frame_start && !input_protocol_select[0]) begin
         sdo_q <= resp[`WORD_BITS-1];
      end else if (launch) begin
         sdo_q <= unified_shift_reg[`WORD_BITS-1];
      end
   end

   // ****************************************************************
   // Source-synchronous read engine
   // ****************************************************************
   logic       ss_mode, ss_ddr, ss_tick, ss_clk_q, next_ss_clk, ss_run, ss_update, ss_done;
   logic [1:0] clk_sel, lane_code, ss_div;
   logic [4:0] ss_left;
   word_t      ss_word;
   logic [3:0] lanes_q;
   assign ss_mode   = output_protocol_select[1:0] == rd_source_sync;
   assign clk_sel   = output_protocol_select[`OUT_CLKSEL_LSB+1:`OUT_CLKSEL_LSB];
   assign lane_code = output_protocol_select[`OUT_LANE_LSB+1:`OUT_LANE_LSB];
   assign ss_ddr    = ss_mode && output_protocol_select[`OUT_RATE_BIT];
   assign ss_run    = ss_mode && !cs_n && !ss_done;
   // Internal clock divider, free running
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ss_div <= 2'b00;
      end else begin
         ss_div <= ss_div + 2'b01;
      end
   end
   always_comb begin
      case (clk_sel)
         2'b01:   ss_tick = 1'b1;
         2'b10:   ss_tick = ss_div[0];
         2'b11:   ss_tick = &ss_div;
         default: ss_tick = 1'b0;
      endcase
      if (!ss_run) begin
         next_ss_clk = 1'b0;
      end else if (clk_sel == 2'b00) begin
         next_ss_clk = link.sclk;
      end else begin
         next_ss_clk = ss_tick ? !ss_clk_q : ss_clk_q;
      end
   end
   // Single rate moves data on the falling output edge, double on both
   assign ss_update = ss_run && (next_ss_clk != ss_clk_q) && (ss_ddr || ss_clk_q);

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ss_clk_q <= 1'b0;
      end else begin
         ss_clk_q <= next_ss_clk;
      end
   end
   // First chunk is set up at the frame start, the rest on each update
   // lane width
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ss_word <= '0;
         lanes_q <= 4'h0;
         ss_left <= 5'd0;
      end else if (frame_start) begin
         ss_word <= resp << lane_step(lane_code);
         lanes_q <= lane_chunk(resp, lane_code);
         ss_left <= 5'(`WORD_BITS) - lane_step(lane_code);
      end else if (ss_update && ss_left != 5'd0) begin
         ss_word <= ss_word << lane_step(lane_code);
         lanes_q <= lane_chunk(ss_word, lane_code);
         ss_left <= ss_left - lane_step(lane_code);
      end
   end
   // The output clock stops once the last chunk has been passed
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ss_done <= 1'b0;
      end else if (frame_start) begin
         ss_done <= 1'b0;
      end else if (ss_update && ss_left == 5'd0) begin
         ss_done <= 1'b1;
      end
   end

   // ****************************************************************
   // Pins and user outputs
   // ****************************************************************
   // lane enables
   assign link.lane_out = ss_mode ? lanes_q : {3'b000, sdo_q};
   assign link.lane_oe  = cs_n ? 4'h0 :
                          !ss_mode ? 4'h1 :
                          (lane_code == 2'b11) ? 4'hf :
                          (lane_code == 2'b10) ? 4'h3 : 4'h1;
   assign link.ss_clk   = ss_clk_q;

   assign light_sleep_enable       = power_bits[`PWR_NAP_BIT];
   assign power_down_request       = power_bits[`PWR_DOWN_BIT];
   assign write_port_spi_mode      = input_protocol_select;
   assign read_protocol_select     = read_mode_e'(output_protocol_select[1:0]);
   assign output_lane_count        = lane_code;
   assign source_sync_clock_select = clk_sel;
   assign data_rate_double         = ss_ddr;
   assign output_word_config       = word_bits;
endmodule : adc_cfg_device

// ==== logic/adc_cfg_host.sv ====
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_host (
   input  wire logic        clock,
   input  wire logic        resetn,
   adc_cfg_if.host          link,
   input  wire logic [7:0]  address,
   input  wire logic [31:0] write_data,
   input  wire logic        write_strobe,
   input  wire logic        read_strobe,
   output      logic [31:0] read_data
);
   import adc_cfg_pkg::*;

   // ****************************************************************
   // Software registers
   // ****************************************************************
   host_state_e     state;
   adc_cfg_pkg::word_t cmd_word;
   logic            cpha;
   logic            cpol;
   logic [1:0]      chain_m1;
   logic [1:0]      target;
   logic            refused;
   logic            key_pending;
   word_t           rx_word;
   word_t           fixed;
   logic            cmd_ok;
   logic            go;
   logic            power_cmd;
   logic            busy;

   assign busy = state != st_idle;

   always_comb begin
      fixed = write_data[`WORD_BITS-1:0];
      if (fixed[`CMD_ADDR_LSB+7:`CMD_ADDR_LSB] == `ADDR_OUTPUT) begin
         fixed[`OUT_RSVD_BIT] = 1'b0;
      end
   end

   assign cmd_ok    = !(fixed[`WORD_BITS-1:`CMD_OP_LSB] == op_write &&
                        fixed[`CMD_ADDR_LSB+7:`CMD_ADDR_LSB] == `ADDR_OUTPUT &&
                        (fixed[1:0] == rd_bad_lo || fixed[1:0] == rd_bad_hi));
   assign go        = write_strobe && address == `HOST_COMMAND && !busy && cmd_ok;
   assign power_cmd = fixed[`WORD_BITS-1:`CMD_OP_LSB] == op_write &&
                      fixed[`CMD_ADDR_LSB+7:`CMD_ADDR_LSB] == `ADDR_POWER;

   // Control changes are ignored while a frame runs
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cpha     <= 1'b0;
         cpol     <= 1'b0;
         chain_m1 <= 2'b00;
         target   <= 2'b00;
      end else if (write_strobe && address == `HOST_CONTROL && !busy) begin
         cpha     <= write_data[`CTL_CPHA_BIT];
         cpol     <= write_data[`CTL_CPOL_BIT];
         chain_m1 <= write_data[`CTL_CHAIN_LSB+1:`CTL_CHAIN_LSB];
         target   <= write_data[`CTL_TARGET_LSB+1:`CTL_TARGET_LSB];
      end
   end

   // Refusal flag: set wins over the clear by an accepted command
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         refused <= 1'b0;
      end else if (write_strobe && address == `HOST_COMMAND && (busy || !cmd_ok)) begin
         refused <= 1'b1;
      end else if (go) begin
         refused <= 1'b0;
      end
   end

   // Read data one cycle after the strobe, zero on unmapped offsets
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         read_data <= 32'h0;
      end else if (read_strobe) begin
         case (address)
            `HOST_COMMAND: read_data <= {12'h000, cmd_word};
            `HOST_CONTROL: read_data <= {26'h0, target, chain_m1, cpol, cpha};
            `HOST_STATUS:  read_data <= {30'h0, refused, busy};
            `HOST_RECEIVE: read_data <= {12'h000, rx_word};
            default:       read_data <= 32'h0;
         endcase
      end
   end

   // ****************************************************************
   // Frame engine
   // ****************************************************************
   logic [7:0]  div;
   logic        tick;
   logic [7:0]  edge_cnt;
   logic [7:0]  last_edge;
   logic [`WORD_BITS*`MAX_CHAIN-1:0] tx;
   logic        sclk_q;
   logic        sdi_q;
   logic        active;
   logic        load;
   word_t       load_word;

   assign tick      = div == 8'(`SCLK_HALF_CYC - 1);
   // exactly twenty capture edges per device
   assign last_edge = 8'((2 * `WORD_BITS) * (chain_m1 + 1) - 1);
   assign load      = go || (state == st_gap && tick && key_pending);
   // key frame precedes a power write
   assign load_word = (go && power_cmd) ? {op_write, `ADDR_KEY, `KEY_VALUE} :
                      go ? fixed : cmd_word;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cmd_word    <= '0;
         key_pending <= 1'b0;
      end else if (go) begin
         cmd_word    <= fixed;
         key_pending <= power_cmd;
      end else if (load) begin
         key_pending <= 1'b0;
      end
   end

   // Half-period divider; also times the tail and the chip-select gap
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div <= 8'h00;
      end else if (load || state == st_idle || tick) begin
         div <= 8'h00;
      end else begin
         div <= div + 8'h01;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state    <= st_idle;
         edge_cnt <= 8'h00;
      end else if (load) begin
         state    <= st_shift;
         edge_cnt <= 8'h00;
      end else if (tick) begin
         case (state)
            st_shift: begin
               edge_cnt <= edge_cnt + 8'h01;
               if (edge_cnt == last_edge) begin
                  state <= st_tail;
               end
            end
            st_tail: state <= st_gap;
            st_gap:  state <= st_idle;
            default: state <= st_idle;
         endcase
      end
   end

   // Clock, data out and data in; phase 0 launches its first bit at load
   // same word to every chained device
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sclk_q  <= 1'b0;
         sdi_q   <= 1'b0;
         tx      <= '0;
         rx_word <= '0;
      end else if (load) begin
         sclk_q <= cpol;
         sdi_q  <= cpha ? 1'b0 : load_word[`WORD_BITS-1];
         tx     <= cpha ? {`MAX_CHAIN{load_word}} : {`MAX_CHAIN{load_word}} << 1;
      end else if (state == st_shift && tick) begin
         sclk_q <= !sclk_q;
         if (edge_cnt[0] != cpha) begin
            sdi_q <= tx[`WORD_BITS*`MAX_CHAIN-1];
            tx    <= tx << 1;
         end else begin
            rx_word <= {rx_word[`WORD_BITS-2:0], link.lane[0]};
         end
      end else if (state == st_idle) begin
         sclk_q <= cpol;
      end
   end

   // frame length fits the chain exactly
   assign active = state == st_shift || state == st_tail;

   // one chip select low at a time
   assign link.cs_n = active ? ~(`STAR_SLOTS'(1) << target) : {`STAR_SLOTS{1'b1}};
   assign link.sclk = sclk_q;
   assign link.sdi  = sdi_q;
endmodule : adc_cfg_host

// ==== test/adc_cfg_assertions.sv ====
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_assertions (
   input wire logic                   clock,
   input wire logic                   resetn,
   input wire logic [`STAR_SLOTS-1:0] cs_n,
   input wire logic                   sclk,
   input wire logic [3:0]             lane_oe,
   input wire logic                   ss_clk
);
   // ****************************************************************
   // Link checks
   // ****************************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   logic       sclk_q;
   logic [7:0] edges;

   // Serial clock toggles in the open frame, cleared between frames
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sclk_q <= 1'b0;
         edges  <= 8'h00;
      end else begin
         sclk_q <= sclk;
         if (&cs_n) edges <= 8'h00;
         else if (sclk != sclk_q) edges <= edges + 8'h01;
      end
   end

   one_select_a: assert property ($onehot0(~cs_n))
      else $error("two chip selects low");
   frame_whole_a: assert property ($rose(&cs_n) |-> edges % 8'd40 == 8'd0)
      else $error("frame not whole words");
   frame_short_a: assert property ($rose(&cs_n) |-> edges >= 8'd40)
      else $error("frame too short");
   lanes_free_a: assert property ((&cs_n)[*4] |-> lane_oe == 4'h0)
      else $error("lanes driven outside frame");
   ss_idle_a: assert property ((&cs_n)[*3] |-> !ss_clk)
      else $error("output clock runs when idle");
   sclk_pace_a: assert property ($changed(sclk) |=> $stable(sclk)[*3])
      else $error("serial clock half period short");
   first_edge_a: assert property ($fell(&cs_n) |-> $stable(sclk)[*3])
      else $error("serial clock moves at frame start");
   cs_gap_a: assert property ($rose(&cs_n) |-> (&cs_n)[*2])
      else $error("chip select gap short");

   // Main scenarios: chained frame, star slot, source-synchronous clock
   cover property ($rose(&cs_n) && edges == 8'd80);
   cover property ($fell(cs_n[1]));
   cover property ($rose(ss_clk));
endmodule : adc_cfg_assertions

// ==== test/adc_serial_config_registers_test.sv ====
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_serial_config_registers_test;
   import adc_cfg_pkg::*;
   // ****************************************************************
   // Bench
   // ****************************************************************
   logic clock = 1'b0, resetn = 1'b0, write_strobe = 1'b0, read_strobe = 1'b0;
   logic [7:0]  address = 8'h00;
   logic [31:0] write_data = 32'h0, read_data;
   logic power_down_request, light_sleep_enable, data_rate_double, command_done;
   logic [1:0]  write_port_spi_mode, output_lane_count, source_sync_clock_select;
   read_mode_e  read_protocol_select;
   logic [5:0]  output_word_config;
   int fail_count = 0;
   int total_checks = 0;
   int done_count = 0;
   adc_cfg_if link ();
   adc_cfg_host u_adc_cfg_host (.clock(clock), .resetn(resetn), .link(link),
      .address(address), .write_data(write_data), .write_strobe(write_strobe),
      .read_strobe(read_strobe), .read_data(read_data));
   adc_cfg_device #(.SLOT(0)) u_adc_cfg_device (.clock(clock), .resetn(resetn),
      .link(link), .power_down_request(power_down_request),
      .light_sleep_enable(light_sleep_enable), .write_port_spi_mode(write_port_spi_mode),
      .read_protocol_select(read_protocol_select), .output_lane_count(output_lane_count),
      .source_sync_clock_select(source_sync_clock_select),
      .data_rate_double(data_rate_double), .output_word_config(output_word_config),
      .command_done(command_done));
   adc_cfg_assertions u_adc_cfg_assertions (.clock(clock), .resetn(resetn), .cs_n(link.cs_n),
      .sclk(link.sclk), .lane_oe(link.lane_oe), .ss_clk(link.ss_clk));

   always #12.5 clock = ~clock;
   // Count decoded frames off the sampling edge
   always @(negedge clock) if (command_done === 1'b1) done_count++;

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   // One-cycle strobes launched just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      @(negedge clock);
      d = read_data;
   endtask : rd
   // Launch a frame, then poll busy with a bound so a hang ends the run
   task automatic cmd(input logic [19:0] w);
      logic [31:0] s;
      int i;
      wr(`HOST_COMMAND, {12'h0, w});
      for (i = 0; i < 3000; i++) begin
         rd(`HOST_STATUS, s);
         if (s[0] === 1'b0) break;
      end
      if (i == 3000) begin
         fail_count++;
         print_verdict();
      end
   endtask : cmd
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      cmd({op_write, a, d});
   endtask : put
   // The answer to a read frame comes back in the following frame
   task automatic rd_back(input logic [7:0] a, input logic [7:0] want);
      logic [31:0] v;
      cmd({op_read, a, 8'h00});
      cmd({op_nop, 16'h0000});
      rd(`HOST_RECEIVE, v);
      chk(v[19:0], {op_read, a, want});
   endtask : rd_back

   task automatic reset_values();
      logic [31:0] s;
      chk({power_down_request, light_sleep_enable, write_port_spi_mode, read_protocol_select,
         output_lane_count, source_sync_clock_select, data_rate_double,
         output_word_config}, 32'h0);
      rd(`HOST_STATUS, s);
      chk(s[1:0], 2'b00);
   endtask : reset_values
   // Modes 1, 2, 3 then back to 0; host follows each new mode
   task automatic input_modes();
      logic [1:0] md;
      for (int m = 1; m < 5; m++) begin
         md = m[1:0];
         put(`ADDR_INPUT, {6'h3f, md});
         wr(`HOST_CONTROL, {30'h0, md});
         chk(write_port_spi_mode, md);
         rd_back(`ADDR_INPUT, {6'h00, md});
      end
   endtask : input_modes
   task automatic power_key();
      for (int d = 3; d >= 0; d--) begin
         put(`ADDR_POWER, {6'h3f, d[1:0]});
         chk({light_sleep_enable, power_down_request}, d[1:0]);
      end
      rd_back(`ADDR_POWER, 8'h00);
   endtask : power_key
   // Every clock source and lane count, double rate, then refusal
   task automatic output_modes();
      logic [31:0] s;
      for (int k = 0; k < 4; k++) begin
         put(`ADDR_OUTPUT, {k[1:0], 2'b11, k[1:0], 2'b11});
         chk({source_sync_clock_select, output_lane_count, data_rate_double,
            read_protocol_select}, {k[1:0], k[1:0], 1'b1, rd_source_sync});
      end
      put(`ADDR_OUTPUT, 8'h3c);
      chk({data_rate_double, read_protocol_select}, {1'b0, rd_follow});
      put(`ADDR_OUTPUT, 8'h01);
      rd(`HOST_STATUS, s);
      chk(s[1:0], 2'b10);
      chk(read_protocol_select, rd_follow);
      rd_back(`ADDR_OUTPUT, 8'h1c);
   endtask : output_modes
   task automatic chain_and_star();
      int n;
      wr(`HOST_CONTROL, 32'h04);
      n = done_count;
      put(`ADDR_WORD, 8'h2a);
      chk(output_word_config, 6'h2a);
      chk(done_count - n, 1);
      wr(`HOST_CONTROL, 32'h10);
      n = done_count;
      put(`ADDR_WORD, 8'h15);
      chk(output_word_config, 6'h2a);
      chk(done_count - n, 0);
      wr(`HOST_CONTROL, 32'h00);
      put(`ADDR_WORD, 8'hff);
      chk(output_word_config, 6'h3f);
      rd_back(8'h20, 8'h00);
   endtask : chain_and_star

   initial begin
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      reset_values();
      input_modes();
      power_key();
      output_modes();
      chain_and_star();
      print_verdict();
   end
endmodule : adc_serial_config_registers_test
